// ===== rtl/pqu_pkg.sv
package pqu_pkg;

    // instruction classes handed over by the integer pipeline
    typedef enum logic [3:0] {
        op_product_to_general_reg = 4'h0,
        op_signed_product_to_pair = 4'h1,
        op_unsigned_product_to_pair = 4'h2,
        op_signed_product_add = 4'h3,
        op_unsigned_product_add = 4'h4,
        op_signed_product_subtract = 4'h5,
        op_unsigned_product_subtract = 4'h6,
        op_move_from_upper = 4'h7,
        op_move_from_bottom = 4'h8,
        op_move_to_upper = 4'h9,
        op_move_to_bottom = 4'hA,
        op_signed_quotient = 4'hB,
        op_unsigned_quotient = 4'hC
    } pqu_op_t;

    // divider states, gray along idle-adjust-iterate-finish
    typedef enum logic [1:0] {
        div_idle = 2'h0,
        div_adjust = 2'h1,
        div_iterate = 2'h3,
        div_finish = 2'h2
    } pqu_div_state_t;

    localparam int unsigned PQU_WORD_W = 32;
    localparam int unsigned PQU_CHUNK_W = 16;
    localparam logic [1:0] PQU_HOLD_ONE_PASS = 2'h1;
    localparam logic [1:0] PQU_HOLD_TWO_PASS = 2'h2;
    localparam logic [5:0] PQU_DIV_LEFT_UNKNOWN = 6'h3F;
    localparam logic [5:0] PQU_DIV_READY_LEFT = 6'h03;
    localparam logic [5:0] PQU_DIV_TAIL = 6'h02;
    localparam logic [5:0] PQU_DIV_BITS_8 = 6'h08;
    localparam logic [5:0] PQU_DIV_BITS_16 = 6'h10;
    localparam logic [5:0] PQU_DIV_BITS_24 = 6'h18;
    localparam logic [5:0] PQU_DIV_BITS_32 = 6'h20;

    function automatic logic op_is_signed(input pqu_op_t op);
        return op == op_product_to_general_reg || op == op_signed_product_to_pair ||
            op == op_signed_product_add || op == op_signed_product_subtract ||
            op == op_signed_quotient;
    endfunction

    function automatic logic op_is_product(input pqu_op_t op);
        return op <= op_unsigned_product_subtract;
    endfunction

    function automatic logic op_is_div(input pqu_op_t op);
        return op == op_signed_quotient || op == op_unsigned_quotient;
    endfunction

    // second operand needs two array passes
    function automatic logic op_two_pass(input pqu_op_t op, input logic [31:0] b);
        logic short_op;
        short_op = op_is_signed(op) ? (b[31:15] == 17'h00000 || b[31:15] == 17'h1FFFF)
                                    : (b[31:16] == 16'h0000);
        return op_is_product(op) && !short_op;
    endfunction

endpackage

// ===== rtl/pqu_mul_pass.sv
// one pass through the 32x16 array, sign-extended to 64 bits
module pqu_mul_pass (
    // operands
    input wire logic [31:0] op_a,
    input wire logic a_signed,
    input wire logic [15:0] chunk,
    input wire logic chunk_signed,
    // product
    output logic [63:0] product
);

    logic signed [32:0] x;
    logic signed [16:0] y;
    logic signed [49:0] p;

    always_comb begin
        x = {a_signed & op_a[31], op_a};
        y = {chunk_signed & chunk[15], chunk};
        p = x * y;
        product = {{14{p[49]}}, p};
    end

endmodule

// ===== rtl/pqu_divider.sv
// one quotient bit per clock with early dividend-width detection
module pqu_divider (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // request
    input wire logic start,
    input wire logic is_signed,
    input wire logic [31:0] dividend,
    input wire logic [31:0] divisor,
    // progress and result
    output logic busy,
    output logic done,
    output logic [5:0] left,
    output logic [31:0] quotient,
    output logic [31:0] remainder
);

    typedef struct packed {
        pqu_pkg::pqu_div_state_t st;
        logic [5:0] left;
        logic sgn;
        logic neg_q;
        logic neg_r;
        logic sadj;
        logic [32:0] rem;
        logic [31:0] quo;
        logic [31:0] dvs;
    } pqu_div_reg_t;

    pqu_div_reg_t s_r;
    pqu_div_reg_t s_nxt;

    logic [31:0] da;
    logic [31:0] db;
    logic [5:0] nbits;
    logic [5:0] sh;
    logic [32:0] trial;

    always_comb begin
        s_nxt = s_r;
        da = s_r.neg_r ? 32'h0 - s_r.quo : s_r.quo;
        db = (s_r.sgn && s_r.dvs[31]) ? 32'h0 - s_r.dvs : s_r.dvs;
        if (da[31:8] == 24'h000000) begin
            nbits = pqu_pkg::PQU_DIV_BITS_8;
        end else if (da[31:16] == 16'h0000) begin
            nbits = pqu_pkg::PQU_DIV_BITS_16;
        end else if (da[31:24] == 8'h00) begin
            nbits = pqu_pkg::PQU_DIV_BITS_24;
        end else begin
            nbits = pqu_pkg::PQU_DIV_BITS_32;
        end
        sh = pqu_pkg::PQU_DIV_BITS_32 - nbits;
        trial = {s_r.rem[31:0], s_r.quo[31]};
        done = s_r.st == pqu_pkg::div_finish && s_r.left == 6'h01;
        case (s_r.st)
            pqu_pkg::div_adjust: begin
                // skipped leading zero bits cost no iterations
                s_nxt.quo = da << sh[4:0];
                s_nxt.dvs = db;
                s_nxt.rem = 33'h0;
                s_nxt.left = nbits + 6'h01 + {5'h00, s_r.sadj};
                s_nxt.st = pqu_pkg::div_iterate;
            end
            pqu_pkg::div_iterate: begin
                if (trial >= {1'b0, s_r.dvs}) begin
                    s_nxt.rem = trial - {1'b0, s_r.dvs};
                    s_nxt.quo = {s_r.quo[30:0], 1'b1};
                end else begin
                    s_nxt.rem = trial;
                    s_nxt.quo = {s_r.quo[30:0], 1'b0};
                end
                s_nxt.left = s_r.left - 6'h01;
                if (s_r.left == pqu_pkg::PQU_DIV_TAIL + {5'h00, s_r.sadj}) begin
                    s_nxt.st = pqu_pkg::div_finish;
                end
            end
            pqu_pkg::div_finish: begin
                // remainder adjust, then sign adjust when needed
                s_nxt.left = s_r.left - 6'h01;
                if (done) begin
                    s_nxt.st = pqu_pkg::div_idle;
                end
            end
            default: begin
                s_nxt.st = pqu_pkg::div_idle;
            end
        endcase
        if (start && (s_r.st == pqu_pkg::div_idle || done)) begin
            s_nxt.st = pqu_pkg::div_adjust;
            s_nxt.left = pqu_pkg::PQU_DIV_LEFT_UNKNOWN;
            s_nxt.sgn = is_signed;
            s_nxt.quo = dividend;
            s_nxt.dvs = divisor;
            s_nxt.neg_q = is_signed & (dividend[31] ^ divisor[31]);
            s_nxt.neg_r = is_signed & dividend[31];
            s_nxt.sadj = is_signed & (dividend[31] | divisor[31]);
        end
        busy = s_r.st != pqu_pkg::div_idle;
        left = s_r.left;
        quotient = s_r.neg_q ? 32'h0 - s_r.quo : s_r.quo;
        remainder = s_r.neg_r ? 32'h0 - s_r.rem[31:0] : s_r.rem[31:0];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ===== rtl/pqu_unit.sv
// Contract
// - targeted product goes to register file
// - accumulate adds, subtract variants subtract product
// - other products write pair; integer continues
// - move-from waits until result available
// - unit pipeline never stalls with integer
// - size from second operand; one/two passes
// - short every clock, long every other
// - divide one bit per clock, early detection
// - any unit op waits for divide
// - latency 1 short, 2 long operand
// - unsigned divide latency 9/17/25/33
// - signed divide one more unless positive
// - move-from to integer latency two; code writes it three cycles after issue, like a short targeted product
// - move-to then accumulate needs no stall
// - targeted product stalls integer one/two cycles
// - dependent next instruction adds one stall
// - back-to-back accumulate repeat 1 or 2
// - computation starts at end of execute
// - long product spends two multiply cycles
// - unit runs decoupled; results to pair
// - pair written in unit writeback stage
// - early detection skips 7/15/23 iterations; code skips 24/16/8 for 8/16/24-bit dividends
module pqu_unit #(
    parameter int unsigned WORD_W = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // issue from the integer pipeline, end of execute
    input wire logic issue_valid,
    input wire pqu_pkg::pqu_op_t issue_op,
    input wire logic [31:0] src_primary,
    input wire logic [31:0] src_second,
    input wire logic consumer_dep,
    // issue control back to the integer pipeline
    output logic issue_ready,
    output logic int_hold,
    // register file result
    output logic gpr_wr_valid,
    output logic [31:0] gpr_wr_data,
    // pair contents and status
    output logic [31:0] upper_result,
    output logic [31:0] bottom_result,
    output logic div_busy
);

    if (WORD_W != pqu_pkg::PQU_WORD_W) begin : g_width_check
        $error("pqu_unit supports a 32-bit word only");
    end

    typedef struct packed {
        logic ready;
        logic hold;
        logic [1:0] hold_left;
        logic dep_done;
        logic m_valid;
        pqu_pkg::pqu_op_t m_op;
        logic [31:0] m_a;
        logic [31:0] m_b;
        logic m_two;
        logic m_pass;
        logic [63:0] m_acc;
        logic a_valid;
        pqu_pkg::pqu_op_t a_op;
        logic [63:0] a_prod;
        logic [31:0] a_data;
        logic w_valid;
        logic [63:0] w_pair;
        logic gpr_valid;
        logic [31:0] gpr_data;
        logic [63:0] pair;
        logic pend_valid;
        logic pend_signed;
        logic [31:0] pend_a;
        logic [31:0] pend_b;
        logic div_busy;
    } pqu_unit_reg_t;

    pqu_unit_reg_t s_r;
    pqu_unit_reg_t s_nxt;

    logic take;
    logic take_two;
    logic take_div;
    logic m_sgn;
    logic [15:0] chunk;
    logic chunk_sgn;
    logic [63:0] pass_prod;
    logic [63:0] full_prod;
    logic [63:0] base;
    logic [63:0] a_result;
    logic dv_busy;
    logic dv_done;
    logic [5:0] dv_left;
    logic [31:0] dv_quo;
    logic [31:0] dv_rem;
    logic dv_free;
    logic dv_start;
    logic dv_signed;
    logic [31:0] dv_a;
    logic [31:0] dv_b;

    pqu_mul_pass u_pass (
        .op_a(s_r.m_a),
        .a_signed(m_sgn),
        .chunk(chunk),
        .chunk_signed(chunk_sgn),
        .product(pass_prod)
    );

    pqu_divider u_div (
        .clock(clock),
        .rst_b(rst_b),
        .start(dv_start),
        .is_signed(dv_signed),
        .dividend(dv_a),
        .divisor(dv_b),
        .busy(dv_busy),
        .done(dv_done),
        .left(dv_left),
        .quotient(dv_quo),
        .remainder(dv_rem)
    );

    // multiply stage operand selection
    always_comb begin
        m_sgn = pqu_pkg::op_is_signed(s_r.m_op);
        chunk = s_r.m_pass ? s_r.m_b[31:16] : s_r.m_b[15:0];
        // low half of a two-pass product is always unsigned
        chunk_sgn = m_sgn && (s_r.m_pass || !s_r.m_two);
        if (s_r.m_pass) begin
            full_prod = s_r.m_acc + {pass_prod[47:0], 16'h0000};
        end else begin
            full_prod = pass_prod;
        end
    end

    // divider start: straight from issue, or from the waiting slot
    always_comb begin
        take = issue_valid && s_r.ready;
        take_two = take && pqu_pkg::op_two_pass(issue_op, src_second);
        take_div = take && pqu_pkg::op_is_div(issue_op);
        dv_free = !dv_busy || dv_done;
        if (s_r.pend_valid) begin
            dv_start = dv_free;
            dv_signed = s_r.pend_signed;
            dv_a = s_r.pend_a;
            dv_b = s_r.pend_b;
        end else begin
            dv_start = take_div && dv_free;
            dv_signed = issue_op == pqu_pkg::op_signed_quotient;
            dv_a = src_primary;
            dv_b = src_second;
        end
    end

    // align stage: carry-propagate add against the bypassed pair
    always_comb begin
        base = s_r.w_valid ? s_r.w_pair : s_r.pair;
        a_result = base;
        case (s_r.a_op)
            pqu_pkg::op_signed_product_to_pair,
            pqu_pkg::op_unsigned_product_to_pair: begin
                a_result = s_r.a_prod;
            end
            pqu_pkg::op_signed_product_add,
            pqu_pkg::op_unsigned_product_add: begin
                a_result = base + s_r.a_prod;
            end
            pqu_pkg::op_signed_product_subtract,
            pqu_pkg::op_unsigned_product_subtract: begin
                a_result = base - s_r.a_prod;
            end
            pqu_pkg::op_move_to_upper: begin
                a_result = {s_r.a_data, base[31:0]};
            end
            pqu_pkg::op_move_to_bottom: begin
                a_result = {base[63:32], s_r.a_data};
            end
            default: begin
                a_result = base;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;

        // multiply stage; no integer stall input reaches it
        if (s_r.m_valid && s_r.m_two && !s_r.m_pass) begin
            s_nxt.m_pass = 1'b1;
            s_nxt.m_acc = pass_prod;
            s_nxt.a_valid = 1'b0;
        end else begin
            s_nxt.a_valid = s_r.m_valid;
            s_nxt.a_op = s_r.m_op;
            s_nxt.a_prod = full_prod;
            s_nxt.a_data = s_r.m_a;
            s_nxt.m_valid = 1'b0;
            s_nxt.m_pass = 1'b0;
        end
        if (take && !pqu_pkg::op_is_div(issue_op)) begin
            s_nxt.m_valid = 1'b1;
            s_nxt.m_op = issue_op;
            s_nxt.m_a = src_primary;
            s_nxt.m_b = src_second;
            s_nxt.m_two = take_two;
            s_nxt.m_pass = 1'b0;
        end

        // writeback stage
        s_nxt.w_valid = s_r.a_valid;
        s_nxt.w_pair = a_result;
        s_nxt.gpr_valid = 1'b0;
        if (s_r.a_valid) begin
            case (s_r.a_op)
                pqu_pkg::op_product_to_general_reg: begin
                    s_nxt.gpr_valid = 1'b1;
                    s_nxt.gpr_data = s_r.a_prod[31:0];
                end
                pqu_pkg::op_move_from_upper: begin
                    s_nxt.gpr_valid = 1'b1;
                    s_nxt.gpr_data = base[63:32];
                end
                pqu_pkg::op_move_from_bottom: begin
                    s_nxt.gpr_valid = 1'b1;
                    s_nxt.gpr_data = base[31:0];
                end
                default: begin
                    s_nxt.gpr_valid = 1'b0;
                end
            endcase
        end

        // pair: unit writeback, or a finished divide
        if (s_r.w_valid) begin
            s_nxt.pair = s_r.w_pair;
        end else if (dv_done) begin
            s_nxt.pair = {dv_rem, dv_quo};
        end

        // waiting divide slot
        if (s_r.pend_valid && dv_free) begin
            s_nxt.pend_valid = 1'b0;
        end
        if (take_div && !dv_start) begin
            s_nxt.pend_valid = 1'b1;
            s_nxt.pend_signed = issue_op == pqu_pkg::op_signed_quotient;
            s_nxt.pend_a = src_primary;
            s_nxt.pend_b = src_second;
        end

        // issue gate: long products every other clock, divides block all
        if (dv_start || take_div || s_nxt.pend_valid) begin
            s_nxt.ready = 1'b0;
        end else if (take_two) begin
            s_nxt.ready = 1'b0;
        end else if (dv_busy) begin
            s_nxt.ready = dv_left <= pqu_pkg::PQU_DIV_READY_LEFT;
        end else begin
            s_nxt.ready = 1'b1;
        end
        s_nxt.div_busy = dv_start || (dv_busy && !dv_done);

        // integer hold for the targeted product's write slot
        if (take && issue_op == pqu_pkg::op_product_to_general_reg) begin
            s_nxt.hold_left = take_two ? pqu_pkg::PQU_HOLD_TWO_PASS
                                       : pqu_pkg::PQU_HOLD_ONE_PASS;
            s_nxt.dep_done = 1'b0;
        end else if (s_r.hold_left != 2'h0) begin
            if (s_r.hold_left == 2'h1 && consumer_dep && !s_r.dep_done) begin
                s_nxt.dep_done = 1'b1;
            end else begin
                s_nxt.hold_left = s_r.hold_left - 2'h1;
            end
        end
        s_nxt.hold = s_nxt.hold_left != 2'h0;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        issue_ready = s_r.ready;
        int_hold = s_r.hold;
        gpr_wr_valid = s_r.gpr_valid;
        gpr_wr_data = s_r.gpr_data;
        upper_result = s_r.pair[63:32];
        bottom_result = s_r.pair[31:0];
        div_busy = s_r.div_busy;
    end

endmodule

// ===== verif/pqu_unit_assertions.sv
module pqu_unit_assertions #(
    parameter int unsigned WORD_W = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // issue
    input wire logic issue_valid,
    input wire pqu_pkg::pqu_op_t issue_op,
    input wire logic [31:0] src_primary,
    input wire logic [31:0] src_second,
    input wire logic consumer_dep,
    // issue control
    input wire logic issue_ready,
    input wire logic int_hold,
    // results
    input wire logic gpr_wr_valid,
    input wire logic [31:0] gpr_wr_data,
    input wire logic [31:0] upper_result,
    input wire logic [31:0] bottom_result,
    input wire logic div_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take, sgn, prod, two, tgt, mvf, dvd;
    assign take = issue_valid && issue_ready;
    assign sgn = issue_op inside {pqu_pkg::op_product_to_general_reg,
        pqu_pkg::op_signed_product_to_pair, pqu_pkg::op_signed_product_add,
        pqu_pkg::op_signed_product_subtract, pqu_pkg::op_signed_quotient};
    assign prod = issue_op <= pqu_pkg::op_unsigned_product_subtract;
    assign two = prod && !(sgn ? (src_second[31:15] == 17'h00000 ||
        src_second[31:15] == 17'h1FFFF) : src_second[31:16] == 16'h0000);
    assign tgt = issue_op == pqu_pkg::op_product_to_general_reg;
    assign mvf = issue_op inside {pqu_pkg::op_move_from_upper, pqu_pkg::op_move_from_bottom};
    assign dvd = issue_op inside {pqu_pkg::op_signed_quotient, pqu_pkg::op_unsigned_quotient};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    gpr_short_a: assert property (take && (tgt && !two || mvf) |-> ##3 gpr_wr_valid)
        else $error("short register file write missing");
    gpr_long_a: assert property (take && tgt && two |-> ##4 gpr_wr_valid)
        else $error("two-pass register file write missing");
    pair_only_a: assert property (take && prod && !tgt |-> ##3 !gpr_wr_valid ##1
        (!$past(two, 4) || !gpr_wr_valid)) else $error("pair product wrote register file");
    hold_short_a: assert property (take && tgt && !two |=>
        int_hold ##1 (int_hold == $past(consumer_dep))) else $error("short hold wrong");
    hold_long_a: assert property (take && tgt && two |=> int_hold [*2])
        else $error("two-pass hold too short");
    short_rate_a: assert property (take && prod && !tgt && !two && !div_busy |=> issue_ready)
        else $error("short product blocked next issue");
    long_gap_a: assert property (take && two |=> !issue_ready)
        else $error("back-to-back two-pass accepted");
    div_block_a: assert property (take && dvd |=> !issue_ready [*8])
        else $error("issue accepted during divide");
    div_busy_a: assert property (take && dvd |=> div_busy)
        else $error("divider not busy after divide issue");
    move_to_a: assert property (take && issue_op == pqu_pkg::op_move_to_bottom |->
        ##4 bottom_result == $past(src_primary, 4)) else $error("move-to data lost");
endmodule

bind pqu_unit pqu_unit_assertions #(.WORD_W(WORD_W)) i_chk (.clock(clock), .rst_b(rst_b),
    .issue_valid(issue_valid), .issue_op(issue_op), .src_primary(src_primary),
    .src_second(src_second), .consumer_dep(consumer_dep), .issue_ready(issue_ready),
    .int_hold(int_hold), .gpr_wr_valid(gpr_wr_valid), .gpr_wr_data(gpr_wr_data),
    .upper_result(upper_result), .bottom_result(bottom_result), .div_busy(div_busy));

// ===== verif/pqu_int_pipe.sv
module pqu_int_pipe (
    // clock
    input wire logic clock,
    // issue toward the unit
    output logic issue_valid,
    output pqu_pkg::pqu_op_t issue_op,
    output logic [31:0] src_primary,
    output logic [31:0] src_second,
    output logic consumer_dep,
    // unit answer
    input wire logic issue_ready,
    input wire logic int_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    int lost;
    initial begin
        issue_valid = 1'b0;
        issue_op = pqu_pkg::op_move_from_bottom;
        src_primary = 32'h0;
        src_second = 32'h0;
        consumer_dep = 1'b0;
        lost = 0;
    end
    // instruction stays in execute until the unit takes it
    task automatic issue(input pqu_pkg::pqu_op_t op, input logic [31:0] a,
        input logic [31:0] b, input logic dep);
        int n;
        n = 0;
        issue_valid <= 1'b1;
        issue_op <= op;
        src_primary <= a;
        src_second <= b;
        consumer_dep <= dep;
        do begin
            @(posedge clock);
            n++;
        end while (issue_ready !== 1'b1 && n < 100);
        if (n == 100) lost++;
        // stalled execute stage offers nothing while the write slot is held
        if (op == pqu_pkg::op_product_to_general_reg) begin
            issue_valid <= 1'b0;
            do begin
                @(posedge clock);
            end while (int_hold === 1'b1);
        end
    endtask
    // released operand lines show a changed pattern
    task automatic idle;
        issue_valid <= 1'b0;
        src_primary <= ~src_primary;
        src_second <= ~src_second;
    endtask
endmodule

// ===== verif/pqu_unit_tb.sv
module pqu_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_b, issue_valid, consumer_dep, issue_ready, int_hold, gpr_wr_valid, div_busy;
    pqu_pkg::pqu_op_t issue_op, op;
    logic [31:0] src_primary, src_second, gpr_wr_data, upper_result, bottom_result;
    logic [63:0] pair_exp;
    logic [31:0] exp_q[$];
    int miscompares, samples_checked;

    pqu_unit i_dut (.clock(clock), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue_op(issue_op), .src_primary(src_primary), .src_second(src_second),
        .consumer_dep(consumer_dep), .issue_ready(issue_ready), .int_hold(int_hold),
        .gpr_wr_valid(gpr_wr_valid), .gpr_wr_data(gpr_wr_data), .upper_result(upper_result),
        .bottom_result(bottom_result), .div_busy(div_busy));
    pqu_int_pipe i_pipe (.clock(clock), .issue_valid(issue_valid), .issue_op(issue_op),
        .src_primary(src_primary), .src_second(src_second), .consumer_dep(consumer_dep),
        .issue_ready(issue_ready), .int_hold(int_hold));

    always #2.5 clock = ~clock;

    task automatic check(input logic [63:0] seen, input logic [63:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic is_sgn(input pqu_pkg::pqu_op_t o);
        return o inside {pqu_pkg::op_product_to_general_reg, pqu_pkg::op_signed_product_to_pair,
            pqu_pkg::op_signed_product_add, pqu_pkg::op_signed_product_subtract};
    endfunction

    // multiplier value of one or two array passes
    function automatic logic [31:0] opnd(input pqu_pkg::pqu_op_t o, input logic long_op);
        logic [31:0] r;
        r = $urandom;
        if (long_op) return {2'b01, r[29:0]};
        if (is_sgn(o)) return {{16{r[15]}}, r[15:0]};
        return {16'h0000, r[15:0]};
    endfunction

    task automatic do_op(input pqu_pkg::pqu_op_t o, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] p;
        p = is_sgn(o) ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
        case (o)
            pqu_pkg::op_product_to_general_reg: exp_q.push_back(p[31:0]);
            pqu_pkg::op_signed_product_to_pair, pqu_pkg::op_unsigned_product_to_pair: pair_exp = p;
            pqu_pkg::op_signed_product_add, pqu_pkg::op_unsigned_product_add: pair_exp += p;
            pqu_pkg::op_signed_product_subtract, pqu_pkg::op_unsigned_product_subtract: pair_exp -= p;
            pqu_pkg::op_move_from_upper: exp_q.push_back(pair_exp[63:32]);
            pqu_pkg::op_move_from_bottom: exp_q.push_back(pair_exp[31:0]);
            pqu_pkg::op_move_to_upper: pair_exp[63:32] = a;
            pqu_pkg::op_move_to_bottom: pair_exp[31:0] = a;
            pqu_pkg::op_signed_quotient: pair_exp = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
            default: pair_exp = {a % b, a / b};
        endcase
        i_pipe.issue(o, a, b, 1'($urandom_range(1)));
    endtask

    task automatic read_pair;
        do_op(pqu_pkg::op_move_from_bottom, 32'h0, 32'h0);
        do_op(pqu_pkg::op_move_from_upper, 32'h0, 32'h0);
    endtask

    // dividend of exactly w bits, sign per case k
    task automatic div_case(input int w, input int k);
        logic [31:0] a, b;
        int cnt;
        a = 32'(($urandom & ((64'h1 << w) - 1)) | (64'h1 << (w - 1)));
        b = {24'h0, 8'($urandom_range(255, 1))};
        if (k == 2) a = -a;
        if (k == 3) b = -b;
        do_op(k > 0 ? pqu_pkg::op_signed_quotient : pqu_pkg::op_unsigned_quotient, a, b);
        i_pipe.idle();
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (issue_ready !== 1'b1 && cnt < 60);
        check(cnt, w + 1 + (k > 1));
        @(posedge clock);
        read_pair();
    endtask

    always @(negedge clock) begin
        if (rst_b === 1'b1 && gpr_wr_valid === 1'b1) begin
            if (exp_q.size() > 0) check(gpr_wr_data, exp_q.pop_front());
            else check(1'b1, 1'b0);
        end
    end

    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        pair_exp = 64'h0;
        void'($urandom(95));
        @(negedge clock);
        check({upper_result, bottom_result}, 64'h0);
        check({issue_ready, int_hold, gpr_wr_valid, div_busy}, 4'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        // random products and accumulates, one or two passes
        for (int i = 0; i < 48; i++) begin
            op = pqu_pkg::pqu_op_t'(4'($urandom_range(6, 1)));
            do_op(op, $urandom, opnd(op, 1'($urandom_range(1))));
            if (i % 3 == 2) read_pair();
        end
        // targeted products keep the pair intact
        for (int i = 0; i < 8; i++) do_op(pqu_pkg::op_product_to_general_reg, $urandom,
            opnd(pqu_pkg::op_product_to_general_reg, i[1]));
        read_pair();
        // move-to straight into an accumulate
        for (int j = 0; j < 2; j++) begin
            op = j ? pqu_pkg::op_unsigned_product_subtract : pqu_pkg::op_signed_product_add;
            do_op(pqu_pkg::op_move_to_upper, $urandom, 32'h0);
            do_op(pqu_pkg::op_move_to_bottom, $urandom, 32'h0);
            do_op(op, $urandom, opnd(op, j[0]));
            read_pair();
        end
        for (int w = 8; w <= 32; w += 8)
            for (int k = 0; k < 4; k++)
                if (w < 32 || k == 0) div_case(w, k);
        // product waits behind a running divide
        do_op(pqu_pkg::op_unsigned_quotient, $urandom, 32'h0000_0007);
        do_op(pqu_pkg::op_unsigned_product_to_pair, $urandom, opnd(op, 1'b0));
        read_pair();
        i_pipe.idle();
        repeat (12) @(posedge clock);
        check(exp_q.size(), 0);
        check(i_pipe.lost, 0);
        check({upper_result, bottom_result}, pair_exp);
        end_of_test();
    end
endmodule
